// ---- include/iwsc_consts.vh ----
`ifndef IWSC_CONSTS_VH
`define IWSC_CONSTS_VH
// Register indices (8-bit registers)
`define IWSC_ADDR_IRQ_CTRL 14'h000b
`define IWSC_ADDR_OPTION 14'h0081
`define IWSC_ADDR_STATUS 14'h0003
`define IWSC_ADDR_CORE_CMD 14'h0100
`define IWSC_ADDR_FUSES 14'h2007
// Interrupt control bits
`define IWSC_GIE_BIT 7
`define IWSC_TOIE_BIT 5
`define IWSC_EXTIE_BIT 4
`define IWSC_PCIE_BIT 3
`define IWSC_TOIF_BIT 2
`define IWSC_EXTIF_BIT 1
`define IWSC_PCIF_BIT 0
// Option bits
`define IWSC_EDGE_BIT 6
`define IWSC_PSA_BIT 3
// Status bits
`define IWSC_TO_N_BIT 4
`define IWSC_PD_N_BIT 3
// Fuse bits
`define IWSC_WATCHDOG_FUSE_ENABLE_BIT 2
// Core command bits (written by the core sequencer)
`define IWSC_CMD_WATCHDOG_CLEAR_INSTR 0
`define IWSC_CMD_SLEEP 1
`define IWSC_CMD_RETURN_FROM_IRQ_INSTR 2
`define IWSC_CMD_ACK 3
// Reset values
`define IWSC_OPTION_RST 8'hff
`define IWSC_FUSES_RST 8'h3f
`define IWSC_IRQ_RST 8'h00
// Timing
`define IWSC_WDT_PERIOD_US 18000
`define IWSC_CLK_MHZ 25
`define IWSC_WDT_CYCLES (`IWSC_WDT_PERIOD_US * `IWSC_CLK_MHZ)
`define IWSC_OST_OSC 1024
`define IWSC_VECTOR 13'h0004
`endif

// ---- verilog/iwsc_stack.v ----
`timescale 1ns/1ps
// Eight-deep return address stack, registered top of stack
module iwsc_stack #(
    parameter DEPTH_LOG = 3,
    parameter WIDTH = 13
) (
    input wire clk_sys, // System clock
    input wire rst_n, // Async reset, active low
    input wire push, // Push return address
    input wire pop, // Pop one entry
    input wire [WIDTH-1:0] push_data, // Address pushed
    output reg [WIDTH-1:0] top // Registered top entry
);
    reg [WIDTH-1:0] mem [0:(1<<DEPTH_LOG)-1];
    reg [DEPTH_LOG-1:0] ptr;
    wire [DEPTH_LOG-1:0] ptr_dec = ptr - {{(DEPTH_LOG-1){1'b0}}, 1'b1};
    wire [DEPTH_LOG-1:0] ptr_dec2 = ptr - {{(DEPTH_LOG-2){1'b0}}, 2'b10};

    // Circular like the real stack: overflow wraps silently
    always @(posedge clk_sys) begin
        if (push)
            mem[ptr] <= push_data;
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ptr <= {DEPTH_LOG{1'b0}};
            top <= {WIDTH{1'b0}};
        end else if (push) begin
            ptr <= ptr + {{(DEPTH_LOG-1){1'b0}}, 1'b1};
            top <= push_data;
        end else if (pop) begin
            ptr <= ptr_dec;
            top <= mem[ptr_dec2];
        end
    end
endmodule

// ---- verilog/iwsc_top.v ----
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "iwsc_consts.vh"
module iwsc_top #(
    parameter WDT_CYCLES = `IWSC_WDT_CYCLES,
    parameter OST_CYCLES = `IWSC_OST_OSC
) (
    input wire clk_sys, // System clock, 25 MHz
    input wire rst_n, // Async reset, active low
    input wire [13:0] addr, // Register address
    input wire [7:0] wdata, // Write data
    input wire wr, // Write strobe
    input wire rd, // Read strobe
    output reg [7:0] rdata, // Read data, cycle after rd
    input wire ext_irq_pin, // External interrupt pin
    input wire [3:0] second_port, // Port bits 7 to 4
    input wire port_read, // Core reads the port this cycle
    input wire timer_overflow, // Timer rolled from ff to 00
    input wire wdt_osc_tick, // Watchdog RC oscillator tick
    input wire [12:0] return_pc, // Address to save on entry
    input wire xtal_mode, // Crystal oscillator mode selected
    output reg irq_req, // Interrupt request to core
    output reg vector_load, // Load vector into PC, pulse
    output reg [12:0] vector_addr, // Vector address
    output reg [12:0] stack_top, // Saved return address
    output reg sleeping, // Oscillator driver off
    output reg wake_pulse, // Execution resumes, pulse
    output reg wdt_reset // Internal reset, pin untouched
);
    localparam ST_RUN = 2'b00;
    localparam ST_SLEEP = 2'b01;
    localparam ST_OST = 2'b10;
    // Terminal counts sized to their counters
    localparam [27:0] WDT_LAST = WDT_CYCLES - 1;
    localparam [10:0] OST_LAST = OST_CYCLES - 1;

    reg [7:0] irq_ctrl;
    reg [7:0] option_control;
    reg [7:0] configuration_fuses;
    reg watchdog_expired_n;
    reg sleep_entered_n;
    reg [1:0] state;
    reg pin_d;
    reg [3:0] port_d;
    reg [27:0] wdt_cnt;
    reg [6:0] presc;
    reg [10:0] ost_cnt;
    reg [1:0] lat_cnt;
    reg lat_busy;
    wire [12:0] stk_top;

    function sel;
        input [13:0] a;
        input [13:0] b;
        sel = (a == b);
    endfunction

    wire wr_ctrl = wr && sel(addr, `IWSC_ADDR_IRQ_CTRL);
    wire wr_cmd = wr && sel(addr, `IWSC_ADDR_CORE_CMD);
    wire cmd_clr = wr_cmd && wdata[`IWSC_CMD_WATCHDOG_CLEAR_INSTR];
    wire cmd_sleep = wr_cmd && wdata[`IWSC_CMD_SLEEP];
    wire cmd_ret = wr_cmd && wdata[`IWSC_CMD_RETURN_FROM_IRQ_INSTR];
    wire cmd_ack = wr_cmd && wdata[`IWSC_CMD_ACK];

    wire edge_sel = option_control[`IWSC_EDGE_BIT];
    wire ext_edge = edge_sel ? (ext_irq_pin && !pin_d)
                             : (!ext_irq_pin && pin_d);
    // Port read hides a coincident change, as the real port latch does
    wire port_chg = (second_port != port_d) && !port_read;

    wire [2:0] pend = {
        irq_ctrl[`IWSC_TOIF_BIT] && irq_ctrl[`IWSC_TOIE_BIT],
        irq_ctrl[`IWSC_EXTIF_BIT] && irq_ctrl[`IWSC_EXTIE_BIT],
        irq_ctrl[`IWSC_PCIF_BIT] && irq_ctrl[`IWSC_PCIE_BIT]};
    wire any_pend = |pend;

    wire wdt_on = configuration_fuses[`IWSC_WATCHDOG_FUSE_ENABLE_BIT];
    wire presc_wdt = option_control[`IWSC_PSA_BIT];
    wire [2:0] ratio = option_control[2:0];
    // Prescaler tap: ratio n divides by 2^n, up to 1:128
    wire presc_hit = (presc == ((7'h01 << ratio) - 7'h01));
    wire wdt_tick = wdt_osc_tick && (!presc_wdt || presc_hit);
    wire wdt_expire = wdt_on && wdt_tick &&
                      (wdt_cnt >= WDT_LAST);
    wire wake_irq = (state == ST_SLEEP) && any_pend;
    wire wake_wdt = (state == ST_SLEEP) && wdt_expire;
    wire wake_any = wake_irq || wake_wdt;
    wire wdt_clear = cmd_clr || cmd_sleep || wake_any;
    wire take_irq = irq_req && cmd_ack && (state == ST_RUN);

    // Edge history, registered inputs
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_d <= 1'b0;
            port_d <= 4'h0;
        end else begin
            pin_d <= ext_irq_pin;
            // Always latched, so a change hidden by a read is lost for good
            port_d <= second_port;
        end
    end

    // Interrupt control: hardware sets win over software clears
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_ctrl <= `IWSC_IRQ_RST;
        end else begin
            if (wr_ctrl)
                irq_ctrl <= wdata;
            if (ext_edge)
                irq_ctrl[`IWSC_EXTIF_BIT] <= 1'b1;
            if (timer_overflow)
                irq_ctrl[`IWSC_TOIF_BIT] <= 1'b1;
            if (port_chg)
                irq_ctrl[`IWSC_PCIF_BIT] <= 1'b1;
            if (take_irq)
                irq_ctrl[`IWSC_GIE_BIT] <= 1'b0;
            else if (cmd_ret)
                irq_ctrl[`IWSC_GIE_BIT] <= 1'b1;
        end
    end

    // Option and fuses (fuses writable by any write to their address)
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            option_control <= `IWSC_OPTION_RST;
            configuration_fuses <= `IWSC_FUSES_RST;
        end else begin
            if (wr && sel(addr, `IWSC_ADDR_OPTION))
                option_control <= wdata;
            if (wr && sel(addr, `IWSC_ADDR_FUSES))
                configuration_fuses <= wdata;
        end
    end

    // Watchdog counts only oscillator ticks, so it runs in sleep
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wdt_cnt <= 28'h0000000;
            presc <= 7'h00;
        end else if (wdt_clear || wdt_expire) begin
            wdt_cnt <= 28'h0000000;
            presc <= 7'h00;
        end else if (wdt_on && wdt_osc_tick) begin
            if (presc_wdt)
                presc <= presc_hit ? 7'h00 : presc + 7'h01;
            if (wdt_tick)
                wdt_cnt <= wdt_cnt + 28'h0000001;
        end
    end

    // Status bits and sleep sequencing
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_expired_n <= 1'b1;
            sleep_entered_n <= 1'b1;
            state <= ST_RUN;
            ost_cnt <= 11'h000;
            sleeping <= 1'b0;
            wake_pulse <= 1'b0;
            wdt_reset <= 1'b0;
        end else begin
            wake_pulse <= 1'b0;
            wdt_reset <= 1'b0;
            if (wdt_expire)
                watchdog_expired_n <= 1'b0;
            if (cmd_clr) begin
                watchdog_expired_n <= 1'b1;
                sleep_entered_n <= 1'b1;
            end
            case (state)
                ST_RUN: begin
                    if (wdt_expire) begin
                        wdt_reset <= 1'b1;
                    end else if (cmd_sleep) begin
                        sleep_entered_n <= 1'b0;
                        watchdog_expired_n <= 1'b1;
                        // Already pending: finish and wake at once
                        if (any_pend) begin
                            wake_pulse <= 1'b1;
                        end else begin
                            state <= ST_SLEEP;
                            sleeping <= 1'b1;
                        end
                    end
                end
                ST_SLEEP: begin
                    if (wake_any) begin
                        if (xtal_mode) begin
                            state <= ST_OST;
                            ost_cnt <= 11'h000;
                        end else begin
                            state <= ST_RUN;
                            sleeping <= 1'b0;
                            wake_pulse <= 1'b1;
                        end
                    end
                end
                ST_OST: begin
                    if (ost_cnt == OST_LAST) begin
                        state <= ST_RUN;
                        sleeping <= 1'b0;
                        wake_pulse <= 1'b1;
                    end else begin
                        ost_cnt <= ost_cnt + 11'h001;
                    end
                end
                default: begin
                    state <= ST_RUN;
                    sleeping <= 1'b0;
                end
            endcase
        end
    end

    // Entry latency: request raised after three cycles of pending
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_req <= 1'b0;
            lat_cnt <= 2'b00;
            lat_busy <= 1'b0;
        end else begin
            if (!(irq_ctrl[`IWSC_GIE_BIT] && any_pend) || sleeping) begin
                lat_cnt <= 2'b00;
                lat_busy <= 1'b0;
                irq_req <= 1'b0;
            end else if (lat_cnt != 2'b10) begin
                lat_busy <= 1'b1;
                lat_cnt <= lat_cnt + 2'b01;
            end else begin
                irq_req <= !take_irq;
            end
        end
    end

    // Vector load and return address save
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            vector_load <= 1'b0;
            vector_addr <= 13'h0000;
            stack_top <= 13'h0000;
        end else begin
            vector_load <= take_irq;
            vector_addr <= `IWSC_VECTOR;
            stack_top <= stk_top;
        end
    end

    // Only the return address is saved; W and status are software's
    iwsc_stack #(
        .DEPTH_LOG(3),
        .WIDTH(13)
    ) u_stack (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .push(take_irq),
        .pop(cmd_ret),
        .push_data(return_pc),
        .top(stk_top)
    );

    // Register readback
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (rd) begin
            if (sel(addr, `IWSC_ADDR_IRQ_CTRL))
                rdata <= irq_ctrl;
            else if (sel(addr, `IWSC_ADDR_OPTION))
                rdata <= option_control;
            else if (sel(addr, `IWSC_ADDR_FUSES))
                rdata <= configuration_fuses & 8'h7f;
            else if (sel(addr, `IWSC_ADDR_STATUS))
                rdata <= {3'b000, watchdog_expired_n, sleep_entered_n,
                          1'b0, lat_busy, state == ST_SLEEP};
            else
                rdata <= 8'h00;
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule

// ---- verif/iwsc_asserts.sv ----
`timescale 1ns/1ps
`include "iwsc_consts.vh"
module iwsc_checker (
    input wire clk_sys, // System clock
    input wire rst_n, // Reset, active low
    input wire [13:0] addr, // Register address
    input wire [7:0] wdata, // Write data
    input wire wr, // Write strobe
    input wire [12:0] return_pc, // Address offered for saving
    input wire irq_req, // Request to core
    input wire vector_load, // Vector load pulse
    input wire [12:0] vector_addr, // Vector address
    input wire [12:0] stack_top, // Saved address
    input wire sleeping, // Oscillator off
    input wire wake_pulse, // Execution resumes
    input wire wdt_reset // Internal reset
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire cmd = wr && (addr == `IWSC_ADDR_CORE_CMD);
    wire ack = cmd && wdata[`IWSC_CMD_ACK];
    wire slp = cmd && wdata[`IWSC_CMD_SLEEP];

    ack_to_vector_a: assert property (ack |=> vector_load && !irq_req)
        else $error("no vector load after acknowledge");
    vector_value_a: assert property (vector_load |-> vector_addr == 13'h0004)
        else $error("wrong vector address");
    global_cleared_a: assert property (ack |=> !irq_req [*8])
        else $error("request while global enable is off");
    return_saved_a: assert property (ack |-> ##[1:4] stack_top == return_pc)
        else $error("return address not on stack");
    sleep_entry_a: assert property (slp && !sleeping |=> sleeping || wake_pulse)
        else $error("sleep command ignored");
    awake_reset_a: assert property (wdt_reset |-> !$past(sleeping))
        else $error("watchdog reset while asleep");
    reset_pulse_a: assert property (wdt_reset |=> !wdt_reset)
        else $error("watchdog reset longer than one cycle");
    wake_exit_a: assert property ($fell(sleeping) |-> wake_pulse || $past(wake_pulse))
        else $error("sleep left without wake pulse");

    cover property (vector_load);
    cover property ($fell(sleeping));
    cover property (wdt_reset);
endmodule

// ---- verif/iwsc_core_model.sv ----
`timescale 1ns/1ps
module iwsc_core_model #(
    parameter RC_HALF_NS = 740
) (
    input wire clk_sys, // System clock
    input wire rst_n, // Reset, active low
    input wire timer_run, // Let the timer count
    output reg wdt_osc_tick, // One pulse per RC period
    output reg timer_overflow, // Pulse on rollover
    output wire [12:0] return_pc // Address to save
);
    reg rc_clk = 1'b0;
    reg [2:0] rc_sync;
    reg [7:0] timer_zero;
    assign return_pc = 13'h0a5c;
    // Unrelated to clk_sys and never stopped, so sleep cannot freeze it
    initial forever #(RC_HALF_NS) rc_clk = ~rc_clk;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rc_sync <= 3'h0;
            timer_zero <= 8'h00;
            wdt_osc_tick <= 1'b0;
            timer_overflow <= 1'b0;
        end else begin
            rc_sync <= {rc_sync[1:0], rc_clk};
            wdt_osc_tick <= rc_sync[1] & ~rc_sync[2];
            timer_zero <= timer_zero + {7'h00, timer_run};
            timer_overflow <= timer_run & (timer_zero == 8'hff);
        end
    end
endmodule

// ---- verif/irq_wdt_sleep_control_tb.sv ----
`timescale 1ns/1ps
`include "iwsc_consts.vh"
module irq_wdt_sleep_control_tb;
    reg clk_sys, rst_n, wr, rd, ext_irq_pin, port_read, xtal_mode, timer_run;
    reg [13:0] addr;
    reg [7:0] wdata, v;
    reg [3:0] second_port;
    wire [7:0] rdata;
    wire [12:0] return_pc, vector_addr, stack_top;
    wire wdt_osc_tick, timer_overflow, irq_req, vector_load;
    wire sleeping, wake_pulse, wdt_reset;
    integer fails = 0, n_tests = 0, cyc, hit, e;

    iwsc_top #(.WDT_CYCLES(20), .OST_CYCLES(8)) iwsc_top_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .ext_irq_pin(ext_irq_pin),
        .second_port(second_port), .port_read(port_read),
        .timer_overflow(timer_overflow), .wdt_osc_tick(wdt_osc_tick),
        .return_pc(return_pc), .xtal_mode(xtal_mode), .irq_req(irq_req),
        .vector_load(vector_load), .vector_addr(vector_addr),
        .stack_top(stack_top), .sleeping(sleeping),
        .wake_pulse(wake_pulse), .wdt_reset(wdt_reset));
    iwsc_core_model iwsc_core_model_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .timer_run(timer_run), .wdt_osc_tick(wdt_osc_tick),
        .timer_overflow(timer_overflow), .return_pc(return_pc));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task chk(input string nm, input [15:0] seen, input [15:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("mismatch %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", n_tests, fails);
            if (fails == 0 && n_tests > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task wreg(input [13:0] a, input [7:0] d);
        begin
            @(posedge clk_sys);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk_sys);
            wr <= 1'b0;
        end
    endtask
    task rreg(input [13:0] a);
        begin
            @(posedge clk_sys);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk_sys);
            rd <= 1'b0;
            #1 v = rdata;
        end
    endtask
    // Pulses are looked at just after each edge so none slips by
    task wait_on(input integer sel, input integer lim);
        begin
            hit = 0;
            for (cyc = 0; cyc < lim && hit == 0; cyc = cyc + 1) begin
                @(posedge clk_sys);
                #1;
                case (sel)
                    0: hit = (irq_req === 1'b1);
                    1: hit = (wake_pulse === 1'b1);
                    2: hit = (wdt_reset === 1'b1);
                    default: hit = (timer_overflow === 1'b1);
                endcase
            end
        end
    endtask
    task need(input integer sel, input integer lim);
        begin
            wait_on(sel, lim);
            if (hit == 0) begin
                chk("wait", 0, 1);
                tally_and_finish;
            end
        end
    endtask
    task pin(input x);
        begin
            @(posedge clk_sys);
            ext_irq_pin <= x;
            repeat (3) @(posedge clk_sys);
        end
    endtask

    initial begin
        {rst_n, wr, rd, ext_irq_pin, port_read, xtal_mode, timer_run} = 7'h00;
        addr = 14'h0000;
        wdata = 8'h00;
        second_port = 4'h0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        rreg(`IWSC_ADDR_IRQ_CTRL);
        chk("irq_ctrl", v, 8'h00);
        rreg(`IWSC_ADDR_STATUS);
        chk("status", v & 8'h18, 8'h18);
        rreg(14'h0042);
        chk("unmapped", v, 8'h00);
        for (e = 0; e < 2; e = e + 1) begin
            wreg(`IWSC_ADDR_OPTION, {1'b1, e[0], 6'h3f});
            pin(e[0]);
            wreg(`IWSC_ADDR_IRQ_CTRL, 8'h00);
            pin(!e[0]);
            rreg(`IWSC_ADDR_IRQ_CTRL);
            chk("wrong edge", v[1], 1'b0);
            pin(e[0]);
            rreg(`IWSC_ADDR_IRQ_CTRL);
            chk("ext flag", v[1], 1'b1);
        end
        chk("masked", irq_req, 1'b0);
        wreg(`IWSC_ADDR_IRQ_CTRL, 8'h12);
        repeat (6) @(posedge clk_sys);
        chk("no global", irq_req, 1'b0);
        wreg(`IWSC_ADDR_IRQ_CTRL, 8'h92);
        need(0, 8);
        wreg(`IWSC_ADDR_CORE_CMD, 8'h08);
        repeat (4) @(posedge clk_sys);
        chk("stack", stack_top, return_pc);
        rreg(`IWSC_ADDR_IRQ_CTRL);
        chk("global off", v[7], 1'b0);
        wreg(`IWSC_ADDR_CORE_CMD, 8'h04);
        rreg(`IWSC_ADDR_IRQ_CTRL);
        chk("global back", v[7], 1'b1);
        $display("test external interrupt done");
        wreg(`IWSC_ADDR_IRQ_CTRL, 8'ha0);
        timer_run <= 1'b1;
        need(3, 300);
        timer_run <= 1'b0;
        need(0, 8);
        wreg(`IWSC_ADDR_IRQ_CTRL, 8'h88);
        port_read <= 1'b1;
        second_port <= 4'h5;
        repeat (3) @(posedge clk_sys);
        port_read <= 1'b0;
        rreg(`IWSC_ADDR_IRQ_CTRL);
        chk("lost change", v[0], 1'b0);
        second_port <= 4'ha;
        need(0, 8);
        $display("test timer and port done");
        wreg(`IWSC_ADDR_IRQ_CTRL, 8'h10);
        pin(1'b0);
        wreg(`IWSC_ADDR_CORE_CMD, 8'h02);
        rreg(`IWSC_ADDR_STATUS);
        chk("sleep status", v & 8'h18, 8'h10);
        chk("asleep", sleeping, 1'b1);
        ext_irq_pin <= 1'b1;
        need(1, 8);
        chk("no vector", irq_req, 1'b0);
        wreg(`IWSC_ADDR_CORE_CMD, 8'h02);
        repeat (3) @(posedge clk_sys);
        chk("pending wake", sleeping, 1'b0);
        wreg(`IWSC_ADDR_IRQ_CTRL, 8'h10);
        pin(1'b0);
        xtal_mode <= 1'b1;
        wreg(`IWSC_ADDR_CORE_CMD, 8'h02);
        ext_irq_pin <= 1'b1;
        need(1, 40);
        chk("start-up wait", cyc > 8, 1'b1);
        xtal_mode <= 1'b0;
        $display("test sleep done");
        wreg(`IWSC_ADDR_OPTION, 8'hf7);
        for (e = 0; e < 3; e = e + 1) begin
            wreg(`IWSC_ADDR_CORE_CMD, 8'h01);
            wait_on(2, 500);
            chk("kept alive", hit, 0);
        end
        // Tick phase is free, so allow one raw tick of slack per step
        for (e = 1; e < 3; e = e + 1) begin
            wreg(`IWSC_ADDR_OPTION, e == 1 ? 8'hf7 : 8'hf9);
            wreg(`IWSC_ADDR_CORE_CMD, 8'h01);
            need(2, 2000);
            chk("period", cyc > 690 * e && cyc < 790 * e, 1'b1);
            rreg(`IWSC_ADDR_STATUS);
            chk("timeout bit", v[4], 1'b0);
        end
        wreg(`IWSC_ADDR_IRQ_CTRL, 8'h00);
        wreg(`IWSC_ADDR_OPTION, 8'hf7);
        wreg(`IWSC_ADDR_CORE_CMD, 8'h02);
        need(1, 800);
        rreg(`IWSC_ADDR_STATUS);
        chk("wdt wake", v & 8'h18, 8'h00);
        wait_on(2, 600);
        chk("cleared on wake", hit, 0);
        $display("test watchdog done");
        tally_and_finish;
    end
endmodule

bind iwsc_top iwsc_checker iwsc_checker_inst (.clk_sys(clk_sys),
    .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .return_pc(return_pc), .irq_req(irq_req), .vector_load(vector_load),
    .vector_addr(vector_addr), .stack_top(stack_top), .sleeping(sleeping),
    .wake_pulse(wake_pulse), .wdt_reset(wdt_reset));
